// file: src/ser_top.sv
// status register bank: service-request mask, operation enable and event latch
`timescale 1ns/1ps
`default_nettype none
module ser_top #(
	parameter int ARG_W = ser_pkg::ARG_W,
	parameter int W = ser_pkg::REG_W
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic rstn, // async power-on reset, active low
	input wire logic cmd_valid, // command present
	input wire logic [1:0] cmd_op, // write or query
	input wire logic [1:0] cmd_sel, // register selected
	input wire logic [ARG_W-1:0] cmd_arg, // integer argument of a write
	input wire logic psc_flag, // power-on-clear flag, held by the host side
	input wire logic [W-1:0] nv_mask_in, // retained mask from the keep-alive store
	input wire logic [W-1:0] cond_in, // operation condition levels
	output logic cmd_ready, // commands are taken
	output logic rsp_valid, // one-cycle answer strobe to a query
	output logic [W-1:0] rsp_data, // answer value
	output logic exec_err, // one-cycle execution error pulse
	output logic [W-1:0] srq_mask, // service-request mask
	output logic [W-1:0] nv_mask_out, // mask value to keep across power loss
	output logic operation_summary_bit_summary_bit // operation summary bit of the status byte
);
	localparam logic [ARG_W-1:0] ARG_MAX = ARG_W'(ser_pkg::MASK_MAX);

	typedef struct packed {
		ser_pkg::ser_state_t st;
		logic rdy;
		logic [W-1:0] srq;
		logic [W-1:0] oen;
		logic summ;
		logic rv;
		logic [W-1:0] rd;
		logic err;
	} ser_top_state_t;

	ser_top_state_t q;
	ser_top_state_t d;
	logic clr_evt;
	logic take;
	logic arg_ok;
	logic [W-1:0] latch_q;
	logic [W-1:0] rise_q;

	// ==================================================================
	// event latch, conditions are pins and synchronised inside
	ser_evt_latch #(
		.W(W)
	) u_evt (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.cond_async(cond_in),
		.clr(clr_evt),
		.latch_q(latch_q),
		.rise_q(rise_q)
	);

	assign take = cmd_valid && q.rdy;
	assign arg_ok = (cmd_arg <= ARG_MAX);

	// ==================================================================
	// command decode and state update
	// the retained mask is picked up one edge after reset release, never
	// under the asynchronous reset itself
	always_comb begin
		d = q;
		d.rv = 1'b0;
		d.err = 1'b0;
		clr_evt = 1'b0;
		d.summ = |(latch_q & q.oen);
		case (q.st)
			ser_pkg::ST_INIT: begin
				if (psc_flag) begin
					d.srq = ser_pkg::SRQ_RST;
				end else begin
					d.srq = nv_mask_in;
				end
				d.st = ser_pkg::ST_RUN;
				d.rdy = 1'b1;
			end
			ser_pkg::ST_RUN: begin
				if (take) begin
					case ({cmd_op, cmd_sel})
						{ser_pkg::OP_WRITE, ser_pkg::SEL_SRQ}: begin
							if (arg_ok) begin
								d.srq = cmd_arg[W-1:0];
							end else begin
								d.err = 1'b1;
							end
						end
						{ser_pkg::OP_WRITE, ser_pkg::SEL_OEN}: begin
							if (arg_ok) begin
								d.oen = cmd_arg[W-1:0];
							end else begin
								d.err = 1'b1;
							end
						end
						{ser_pkg::OP_QUERY, ser_pkg::SEL_SRQ}: begin
							d.rv = 1'b1;
							d.rd = q.srq;
						end
						{ser_pkg::OP_QUERY, ser_pkg::SEL_OEN}: begin
							d.rv = 1'b1;
							d.rd = q.oen;
						end
						{ser_pkg::OP_QUERY, ser_pkg::SEL_OEV}: begin
							d.rv = 1'b1;
							d.rd = latch_q;
							clr_evt = 1'b1;
						end
						default: begin
							d.err = 1'b1; // writes to the latch, unknown codes
						end
					endcase
				end
			end
			default: begin
				d.st = ser_pkg::ST_INIT;
				d.rdy = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q.st <= ser_pkg::ST_INIT;
			q.rdy <= 1'b0;
			q.srq <= ser_pkg::SRQ_RST;
			q.oen <= ser_pkg::OEN_RST;
			q.summ <= 1'b0;
			q.rv <= 1'b0;
			q.rd <= ser_pkg::EVT_RST;
			q.err <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// outputs, all straight from flops
	assign cmd_ready = q.rdy;
	assign rsp_valid = q.rv;
	assign rsp_data = q.rd;
	assign exec_err = q.err;
	assign srq_mask = q.srq;
	assign nv_mask_out = q.srq;
	assign operation_summary_bit_summary_bit = q.summ;

	// ==================================================================
	// checks
	property p_srq_write;
		@(posedge clk_sys) disable iff (!rstn)
		(take && cmd_op == ser_pkg::OP_WRITE && cmd_sel == ser_pkg::SEL_SRQ && arg_ok)
		|=> (srq_mask == $past(cmd_arg[W-1:0])) && !exec_err;
	endproperty
	a_srq_write: assert property (p_srq_write) else $error("mask write lost");

	property p_srq_bad;
		@(posedge clk_sys) disable iff (!rstn)
		(take && cmd_op == ser_pkg::OP_WRITE && cmd_sel == ser_pkg::SEL_SRQ && !arg_ok)
		|=> exec_err && $stable(srq_mask);
	endproperty
	a_srq_bad: assert property (p_srq_bad) else $error("bad mask argument accepted");

	property p_psc_clear;
		@(posedge clk_sys) disable iff (!rstn)
		(q.st == ser_pkg::ST_INIT && psc_flag) |=> (srq_mask == ser_pkg::SRQ_RST) && cmd_ready;
	endproperty
	a_psc_clear: assert property (p_psc_clear) else $error("mask not cleared at power-up");

	property p_psc_keep;
		@(posedge clk_sys) disable iff (!rstn)
		(q.st == ser_pkg::ST_INIT && !psc_flag) |=> (srq_mask == $past(nv_mask_in));
	endproperty
	a_psc_keep: assert property (p_psc_keep) else $error("retained mask not restored");

	// write, one idle cycle, then readback; the idle cycle keeps the mask untouched
	property p_oen_write;
		@(posedge clk_sys) disable iff (!rstn)
		(take && cmd_op == ser_pkg::OP_WRITE && cmd_sel == ser_pkg::SEL_OEN && arg_ok)
		##1 !take
		##1 (take && cmd_op == ser_pkg::OP_QUERY && cmd_sel == ser_pkg::SEL_OEN)
		|=> rsp_valid && (rsp_data == $past(cmd_arg[W-1:0], 3));
	endproperty
	a_oen_write: assert property (p_oen_write) else $error("enable mask readback wrong");

	// out-of-range enable argument must not reach the mask
	property p_oen_bad;
		@(posedge clk_sys) disable iff (!rstn)
		(take && cmd_op == ser_pkg::OP_WRITE && cmd_sel == ser_pkg::SEL_OEN && !arg_ok)
		|=> exec_err && $stable(q.oen);
	endproperty
	a_oen_bad: assert property (p_oen_bad) else $error("bad enable argument accepted");

	property p_summary;
		@(posedge clk_sys) disable iff (!rstn)
		q.st == ser_pkg::ST_RUN |=> (operation_summary_bit_summary_bit == |($past(latch_q) & $past(q.oen)));
	endproperty
	a_summary: assert property (p_summary) else $error("summary bit wrong");

	property p_evt_query;
		@(posedge clk_sys) disable iff (!rstn)
		(take && cmd_op == ser_pkg::OP_QUERY && cmd_sel == ser_pkg::SEL_OEV)
		|=> rsp_valid && (rsp_data == $past(latch_q)) && (latch_q == $past(rise_q));
	endproperty
	a_evt_query: assert property (p_evt_query) else $error("event query wrong");

	property p_no_spurious;
		@(posedge clk_sys) disable iff (!rstn)
		!take |=> !rsp_valid && !exec_err;
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("answer without command");
endmodule // ser_top
`default_nettype wire

// file: src/ser_pkg.sv
// package of constants and types for the status enable and event registers
package ser_pkg;
	// ==================================================================
	// widths and ranges
	localparam int REG_W = 8;
	localparam int ARG_W = 16;
	localparam logic [REG_W-1:0] MASK_MAX = 8'hFF;
	// ==================================================================
	// reset values
	localparam logic [REG_W-1:0] SRQ_RST = 8'h00;
	localparam logic [REG_W-1:0] OEN_RST = 8'h00;
	localparam logic [REG_W-1:0] EVT_RST = 8'h00;
	// ==================================================================
	// command codes on the remote command port
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_WRITE = 2'b01,
		OP_QUERY = 2'b10
	} ser_op_t;
	typedef enum logic [1:0] {
		SEL_SRQ = 2'b00,
		SEL_OEN = 2'b01,
		SEL_OEV = 2'b10
	} ser_sel_t;
	// ==================================================================
	// control states
	typedef enum logic [0:0] {
		ST_INIT = 1'b0,
		ST_RUN = 1'b1
	} ser_state_t;
endpackage

// file: src/ser_evt_latch.sv
// rising-edge event latch with read clear for the operation conditions
`timescale 1ns/1ps
`default_nettype none
module ser_evt_latch #(
	parameter int W = 8
) (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic [W-1:0] cond_async, // condition levels from outside
	input wire logic clr, // one-cycle clear pulse from a query
	output logic [W-1:0] latch_q, // latched events
	output logic [W-1:0] rise_q // rising edges seen this cycle
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] prev;
		logic [W-1:0] latch;
	} ser_evl_state_t;

	ser_evl_state_t q;
	ser_evl_state_t d;
	logic [W-1:0] rise;

	// ==================================================================
	// synchroniser, edge detect and sticky latch
	// set wins over clear so an edge in the query cycle is kept
	always_comb begin
		d = q;
		d.s1 = cond_async;
		d.s2 = q.s1;
		d.prev = q.s2;
		rise = q.s2 & ~q.prev;
		d.latch = (q.latch & ~{W{clr}}) | rise;
	end

	// state register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign latch_q = q.latch;
	assign rise_q = rise;

	// ==================================================================
	// checks
	property p_evt_set;
		@(posedge clk_sys) disable iff (!rstn)
		(rise != '0) |=> ((latch_q & $past(rise)) == $past(rise));
	endproperty
	a_evt_set: assert property (p_evt_set) else $error("edge not latched");

	property p_evt_hold;
		@(posedge clk_sys) disable iff (!rstn)
		!clr |=> ((latch_q & $past(latch_q)) == $past(latch_q));
	endproperty
	a_evt_hold: assert property (p_evt_hold) else $error("event lost without read");

	property p_evt_clear;
		@(posedge clk_sys) disable iff (!rstn)
		clr |=> (latch_q == $past(rise));
	endproperty
	a_evt_clear: assert property (p_evt_clear) else $error("read did not clear latch");
endmodule // ser_evt_latch
`default_nettype wire

// file: testbench/ser_host.sv
// remote host model that issues status commands
`timescale 1ns/1ps
`default_nettype none
module ser_host (
	input wire logic clk_sys, // system clock
	input wire logic cmd_ready, // device takes commands
	output logic cmd_valid = 1'b0, // command present
	output logic [1:0] cmd_op = 2'h0, // write or query
	output logic [1:0] cmd_sel = 2'h0, // register selected
	output logic [15:0] cmd_arg = 16'h0000 // write argument
);
	// ==========
	// hold the command until the edge that takes it, then scramble the argument
	task automatic issue(input logic [1:0] op, input logic [1:0] sel, input logic [15:0] arg);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_sel <= sel;
		cmd_arg <= arg;
		@(posedge clk_sys);
		while (cmd_ready !== 1'b1) @(posedge clk_sys);
		cmd_valid <= 1'b0;
		cmd_arg <= ~arg; // stale argument must not be reused
	endtask
endmodule // ser_host
`default_nettype wire

// file: testbench/status_enable_event_regs_bench.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
`default_nettype none
module status_enable_event_regs_bench;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic psc_flag = 1'b1;
	logic [7:0] nv_mask_in = 8'h00;
	logic [7:0] cond_in = 8'h00;
	logic cmd_valid, cmd_ready, rsp_valid, exec_err, operation_summary_bit_summary_bit;
	logic [1:0] cmd_op, cmd_sel;
	logic [15:0] cmd_arg;
	logic [7:0] rsp_data, srq_mask, nv_mask_out;
	int errors = 0;
	int num_checks = 0;
	int srq, oen, evt, v;
	logic [31:0] lf = 32'hAC8E0774;
	// ==========
	// clock, partner and device
	always #5 clk_sys = ~clk_sys;
	ser_host host (.clk_sys(clk_sys), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_arg(cmd_arg));
	ser_top DUT (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_sel(cmd_sel), .cmd_arg(cmd_arg), .psc_flag(psc_flag), .nv_mask_in(nv_mask_in),
		.cond_in(cond_in), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.exec_err(exec_err), .srq_mask(srq_mask), .nv_mask_out(nv_mask_out),
		.operation_summary_bit_summary_bit(operation_summary_bit_summary_bit));
	// ==========
	// helpers
	function automatic logic [8:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[8:0];
	endfunction
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %0h seen %0h", n, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// reset held low for 7 cycles; the oen and evt model values restart with it
	task automatic do_reset(input logic psc, input logic [7:0] keep);
		@(posedge clk_sys);
		rstn <= 1'b0;
		psc_flag <= psc;
		nv_mask_in <= keep;
		repeat (6) @(posedge clk_sys);
		#1;
		chk("cmd_ready", {7'h00, cmd_ready}, 8'h00);
		@(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		oen = 0;
		evt = 0;
	endtask
	// one command; answer checked in the cycle after the taking edge, rsp -1 = none
	task automatic cmd(input logic [1:0] op, input logic [1:0] sel, input int arg,
		input int rsp, input logic err);
		host.issue(op, sel, arg[15:0]);
		#1;
		chk("exec_err", {7'h00, exec_err}, {7'h00, err});
		chk("rsp_valid", {7'h00, rsp_valid}, {7'h00, rsp >= 0});
		if (rsp >= 0) chk("rsp_data", rsp_data, rsp[7:0]);
		chk("srq_mask", srq_mask, srq[7:0]);
		chk("nv_mask_out", nv_mask_out, srq[7:0]);
	endtask
	// ==========
	// main sequence
	initial begin
		v = rnd();
		do_reset(1'b1, v[7:0] | 8'h01);
		chk("srq_mask", srq_mask, 8'h00);
		chk("cmd_ready", {7'h00, cmd_ready}, 8'h01);
		v = rnd();
		do_reset(1'b0, v[7:0] | 8'h01);
		srq = nv_mask_in;
		chk("srq_mask", srq_mask, srq[7:0]);
		cmd(ser_pkg::OP_WRITE, ser_pkg::SEL_OEV, 5, -1, 1'b1);
		cmd(ser_pkg::OP_NONE, ser_pkg::SEL_SRQ, 0, -1, 1'b1);
		for (int i = 0; i < 16; i++) begin
			// boundaries first, then random values that may be out of range
			v = (i == 0) ? 0 : (i == 1) ? 255 : (i == 2) ? 256 : rnd();
			if (v < 256) srq = v;
			cmd(ser_pkg::OP_WRITE, ser_pkg::SEL_SRQ, v, -1, v > 255);
			cmd(ser_pkg::OP_QUERY, ser_pkg::SEL_SRQ, 0, srq, 1'b0);
			if (v < 256) oen = v;
			cmd(ser_pkg::OP_WRITE, ser_pkg::SEL_OEN, v, -1, v > 255);
			cmd(ser_pkg::OP_QUERY, ser_pkg::SEL_OEN, 0, oen, 1'b0);
			// pulse conditions; the fall must not clear what was latched
			v = rnd();
			@(posedge clk_sys);
			cond_in <= v[7:0];
			repeat (3) @(posedge clk_sys);
			cond_in <= 8'h00;
			repeat (6) @(posedge clk_sys);
			#1;
			evt = evt | v[7:0];
			chk("summary", {7'h00, operation_summary_bit_summary_bit}, {7'h00, (evt & oen) != 0});
			// read every other round so events accumulate in between
			if (i % 2 == 1) begin
				cmd(ser_pkg::OP_QUERY, ser_pkg::SEL_OEV, 0, evt, 1'b0);
				evt = 0;
				cmd(ser_pkg::OP_QUERY, ser_pkg::SEL_OEV, 0, 0, 1'b0);
				chk("summary", {7'h00, operation_summary_bit_summary_bit}, 8'h00);
			end
		end
		end_sim();
	end
	// ==========
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		errors++;
		end_sim();
	end
endmodule // status_enable_event_regs_bench
`default_nettype wire
